// file: logic/clock_gen_pkg.sv
// Register map, field layout, reset values and carrier types of the clock generation block
package clock_gen_pkg;
  localparam logic [7:0] TRIM_OFS = 8'h00;
  localparam logic [7:0] CLKSEL_OFS = 8'h04;
  localparam logic [7:0] TRIMCTRL_OFS = 8'h08;
  localparam logic [7:0] RDYSTART_OFS = 8'h0c;
  localparam logic [7:0] RDYCAP_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] CALCTRL_OFS = 8'h18;
  localparam logic [7:0] CALN_OFS = 8'h1c;
  localparam logic [7:0] CALRES_OFS = 8'h20;
  localparam int TRIM_W = 11;
  localparam int TRIM_BIN_W = 8;
  localparam int THERM_W = 7;
  localparam int RDY_W = 16;
  localparam int CNTN_W = 8;
  localparam int CALN_W = 16;
  localparam int DIV_W = 4;
  localparam int LP_SEL_LSB = 0;
  localparam int SYS_SEL_LSB = 4;
  localparam int EXT_DIV_LSB = 8;
  localparam int TRIM_SEL_LSB = 0;
  localparam int COUNT_N_LSB = 8;
  localparam int REF_SEL_LSB = 0;
  localparam int CAL_START_BIT = 2;
  localparam int ST_TRIM_DONE_BIT = 0;
  localparam int ST_XTAL_EN_BIT = 1;
  localparam int ST_SEQ_LSB = 2;
  localparam int ST_PLL_LSB = 4;
  localparam int ST_RDY_LSB = 16;
  localparam logic [TRIM_W-1:0] TRIM_RST = 11'h000;
  localparam logic [1:0] LP_SEL_RST = 2'h1;
  localparam logic [1:0] LP_RSVD = 2'h3;
  localparam logic [2:0] SYS_RSVD = 3'h7;
  localparam logic [RDY_W-1:0] RDY_START_RST = 16'h0020;
  localparam logic [RDY_W-1:0] RDY_ONE = 16'h0001;
  localparam logic [CNTN_W-1:0] COUNT_N_RST = 8'h40;
  localparam logic [CALN_W-1:0] CAL_ONE = 16'h0001;
  localparam logic [DIV_W-1:0] EXT_DIV_RST = 4'h1;
  localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;
  // 96 MHz PLL output over the 16 MHz divided clock
  localparam logic [DIV_W-1:0] PLL_DIV = 4'h6;

  typedef enum logic [2:0] {
    SYS_FAST_RC = 3'b000, SYS_FAST_XTAL = 3'b001, SYS_PLL = 3'b010, SYS_EXT = 3'b011,
    SYS_SLOW_RC = 3'b100, SYS_SLOW_XTAL = 3'b101, SYS_ENH_RC = 3'b110
  } sys_src_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_STARTUP = 2'b01, SEQ_SETTLE = 2'b10, SEQ_READY = 2'b11
  } seq_state_t;
  typedef enum logic [1:0] {PLL_OFF = 2'b00, PLL_LOCKING = 2'b01, PLL_ON = 2'b10} pll_state_t;

  typedef struct packed {
    logic psel; logic penable; logic pwrite; logic [7:0] paddr; logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {logic pready; logic [31:0] prdata; logic pslverr;} apb_rsp_t;
  typedef struct packed {
    logic fast_crystal_osc; logic fast_rc_osc; logic slow_rc_osc;
    logic slow_crystal_osc; logic enhanced_rc_osc; logic sys_clk_mon;
  } osc_in_t;
  typedef struct packed {logic [THERM_W-1:0] therm; logic [TRIM_BIN_W-1:0] bin;} trim_caps_t;
  typedef struct packed {logic prev; logic [DIV_W-1:0] cnt; logic tick;} divn_state_t;
  typedef struct packed {
    logic [TRIM_W-1:0] trim_code; logic [TRIM_W-1:0] trim_applied;
    logic [1:0] lp_sel; sys_src_t sys_sel; sys_src_t sys_applied; logic [DIV_W-1:0] ext_div;
    logic [1:0] trim_select; logic [CNTN_W-1:0] count_n; logic [CNTN_W-1:0] xtal_cnt;
    logic [RDY_W-1:0] rdy_start; logic [RDY_W-1:0] rdy_cnt; logic [RDY_W-1:0] rdy_cap;
    seq_state_t seq; pll_state_t pll; logic wakeup; logic xtal_en; logic trim_done; logic irq;
    logic ok_prev; osc_in_t osc_prev; logic [1:0] ref_sel; logic cal_start;
    logic [CALN_W-1:0] cal_n; logic [CALN_W-1:0] cal_left; logic [31:0] cal_m;
    logic [31:0] cal_res; logic [31:0] prdata; logic pslverr;
  } core_state_t;
endpackage : clock_gen_pkg

// file: logic/trim_cap_decoder.sv
// Crystal trim code to capacitor bank controls, registered
`timescale 1ns/100ps
module trim_cap_decoder
  import clock_gen_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [TRIM_W-1:0] code,
  output trim_caps_t caps
);
  trim_caps_t s_q;
  trim_caps_t s_d;

  function automatic logic [THERM_W-1:0] therm(input logic [2:0] msb);
    logic [THERM_W-1:0] t;
    t = '0;
    for (int i = 0; i < THERM_W; i++) begin
      t[i] = (i == 0) || (msb > 3'(i));
    end
    return t;
  endfunction : therm

  always_comb begin
    s_d = s_q;
    s_d.bin = code[TRIM_BIN_W-1:0];
    // Thermometer lines 1 to 6 each switch a capacitor of 256 unit steps; line 0 is always on
    s_d.therm = therm(code[TRIM_W-1:TRIM_BIN_W]);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Both banks share these lines, so one code moves both equally
  assign caps = s_q;
endmodule : trim_cap_decoder

// file: logic/divn_divider.sv
// Divider of the system clock: by 6 on the PLL, by a nonzero ext_div on the external clock, by one otherwise
`timescale 1ns/100ps
module divn_divider
  import clock_gen_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sys_src_t sys_src,
  input wire logic [DIV_W-1:0] ext_div,
  input wire logic sys_clk_mon,
  output logic divn_tick
);
  divn_state_t s_q;
  divn_state_t s_d;
  logic [DIV_W-1:0] factor;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.prev = sys_clk_mon;
    if (sys_src == SYS_PLL) begin
      factor = PLL_DIV;
    end else if (sys_src == SYS_EXT && ext_div != '0) begin
      factor = ext_div;
    end else begin
      factor = DIV_ONE;
    end
    if (sys_clk_mon && !s_q.prev) begin
      if (s_q.cnt >= factor - DIV_ONE) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + DIV_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign divn_tick = s_q.tick;
endmodule : divn_divider

// file: logic/clock_gen_xtal_trim_calib.sv
// Clock selection, crystal start-up and trim sequencing, and reference calibration
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
module clock_gen_xtal_trim_calib
  import clock_gen_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire osc_in_t osc,
  input wire logic crystal_amplitude_ok,
  input wire logic pll_locked,
  input wire logic power_up_start,
  input wire logic wakeup_start,
  input wire logic xtal_disable,
  output logic [1:0] low_power_sleep_clock,
  output sys_src_t sys_clk_sel,
  output logic fast_crystal_enable,
  output logic pll_enable,
  output logic usb48_enable,
  output logic divn_tick,
  output trim_caps_t trim_caps,
  output logic trim_done_flag,
  output logic crystal_ready_interrupt
);
  core_state_t s_q;
  core_state_t s_d;
  osc_in_t rise;
  logic ok_rise;
  logic rdy_tick;
  logic ref_edge;
  logic startup_end;
  logic set_done;
  logic setup;
  logic wr;
  logic [31:0] rd;
  logic divn_tick_w;

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == TRIM_OFS) || (a == CLKSEL_OFS) || (a == TRIMCTRL_OFS) ||
           (a == RDYSTART_OFS) || (a == RDYCAP_OFS) || (a == STATUS_OFS) ||
           (a == CALCTRL_OFS) || (a == CALN_OFS) || (a == CALRES_OFS);
  endfunction : reg_hit

  function automatic logic lp_edge(input logic [1:0] sel, input osc_in_t r);
    if (sel == 2'h0) begin
      return r.enhanced_rc_osc;
    end else if (sel == 2'h2) begin
      return r.slow_crystal_osc;
    end
    return r.slow_rc_osc;
  endfunction : lp_edge

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    set_done = 1'b0;
    rise = osc_in_t'(osc & ~s_q.osc_prev);
    s_d.osc_prev = osc;
    ok_rise = crystal_amplitude_ok && !s_q.ok_prev;
    s_d.ok_prev = crystal_amplitude_ok;
    // Power-up counts on the slow RC; wake-up counts on the sleep clock
    rdy_tick = s_q.wakeup ? lp_edge(s_q.lp_sel, rise) : rise.slow_rc_osc;
    startup_end = s_q.trim_select[1] ? (s_q.xtal_cnt >= s_q.count_n)
                                     : crystal_amplitude_ok;
    // Reference edge per selection: 0 slow RC, 1 fast RC, 2 slow crystal, 3 enhanced RC
    case (s_q.ref_sel)
      2'h0: ref_edge = rise.slow_rc_osc;
      2'h1: ref_edge = rise.fast_rc_osc;
      2'h2: ref_edge = rise.slow_crystal_osc;
      default: ref_edge = rise.enhanced_rc_osc;
    endcase

    // Register writes take effect in the access phase
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && reg_hit(apb_req.paddr);
    if (wr) begin
      if (apb_req.paddr == TRIM_OFS) begin
        s_d.trim_code = apb_req.pwdata[TRIM_W-1:0];
      end else if (apb_req.paddr == CLKSEL_OFS) begin
        // Reserved code would leave the sleep domain without a source
        if (apb_req.pwdata[LP_SEL_LSB +: 2] != LP_RSVD) begin
          s_d.lp_sel = apb_req.pwdata[LP_SEL_LSB +: 2];
        end
        if (apb_req.pwdata[SYS_SEL_LSB +: 3] != SYS_RSVD) begin
          s_d.sys_sel = sys_src_t'(apb_req.pwdata[SYS_SEL_LSB +: 3]);
        end
        s_d.ext_div = apb_req.pwdata[EXT_DIV_LSB +: DIV_W];
      end else if (apb_req.paddr == TRIMCTRL_OFS) begin
        s_d.trim_select = apb_req.pwdata[TRIM_SEL_LSB +: 2];
        s_d.count_n = apb_req.pwdata[COUNT_N_LSB +: CNTN_W];
      end else if (apb_req.paddr == RDYSTART_OFS) begin
        s_d.rdy_start = apb_req.pwdata[RDY_W-1:0];
      end else if (apb_req.paddr == CALCTRL_OFS) begin
        // Selection is frozen while a measurement runs
        if (!s_q.cal_start) begin
          s_d.ref_sel = apb_req.pwdata[REF_SEL_LSB +: 2];
          if (apb_req.pwdata[CAL_START_BIT]) begin
            s_d.cal_start = 1'b1;
            s_d.cal_left = s_q.cal_n;
            s_d.cal_m = '0;
          end
        end
      end else if (apb_req.paddr == CALN_OFS) begin
        s_d.cal_n = apb_req.pwdata[CALN_W-1:0];
      end
    end

    // Crystal start-up, trim and settling sequence
    if (s_q.seq == SEQ_STARTUP && rise.fast_crystal_osc && s_q.xtal_cnt != '1) begin
      s_d.xtal_cnt = s_q.xtal_cnt + 8'h01;
    end
    case (s_q.seq)
      SEQ_IDLE: begin
        if (power_up_start || wakeup_start) begin
          s_d.seq = SEQ_STARTUP;
          s_d.xtal_en = 1'b1;
          s_d.wakeup = wakeup_start && !power_up_start;
          s_d.rdy_cnt = s_q.rdy_start;
          s_d.xtal_cnt = '0;
        end
      end
      SEQ_STARTUP: begin
        if (rdy_tick && s_q.rdy_cnt > RDY_ONE) begin
          s_d.rdy_cnt = s_q.rdy_cnt - RDY_ONE;
        end
        if (startup_end) begin
          s_d.trim_applied = s_q.trim_code;
          set_done = 1'b1;
          s_d.seq = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        // Interrupt waits for trim so the crystal is always trimmed when announced
        if (s_q.rdy_cnt <= RDY_ONE) begin
          s_d.irq = 1'b1;
          s_d.seq = SEQ_READY;
        end else if (rdy_tick) begin
          s_d.rdy_cnt = s_q.rdy_cnt - RDY_ONE;
        end
      end
      SEQ_READY: begin
        s_d.seq = SEQ_READY;
      end
      default: begin
        s_d.seq = SEQ_IDLE;
      end
    endcase
    if (set_done) begin
      s_d.trim_done = 1'b1;
    end
    if (xtal_disable) begin
      s_d.seq = SEQ_IDLE;
      s_d.xtal_en = 1'b0;
      s_d.irq = 1'b0;
      if (!s_q.trim_select[1] && !set_done) begin
        s_d.trim_done = 1'b0;
      end
    end
    if (ok_rise) begin
      s_d.rdy_cap = s_q.rdy_cnt;
    end

    // PLL request waits for lock before the system clock moves onto it
    case (s_q.pll)
      PLL_OFF: begin
        if (s_q.sys_sel == SYS_PLL && s_q.seq == SEQ_READY) begin
          s_d.pll = PLL_LOCKING;
        end else if (s_q.sys_sel != SYS_PLL) begin
          s_d.sys_applied = s_q.sys_sel;
        end
      end
      PLL_LOCKING: begin
        if (s_q.sys_sel != SYS_PLL) begin
          s_d.pll = PLL_OFF;
        end else if (pll_locked) begin
          s_d.pll = PLL_ON;
          s_d.sys_applied = SYS_PLL;
        end
      end
      PLL_ON: begin
        if (s_q.sys_sel != SYS_PLL) begin
          s_d.sys_applied = s_q.sys_sel;
          s_d.pll = PLL_OFF;
        end
      end
      default: begin
        s_d.pll = PLL_OFF;
      end
    endcase
    // Losing the crystal takes the PLL down; fall back to the fast RC
    if (xtal_disable && s_q.pll != PLL_OFF) begin
      s_d.pll = PLL_OFF;
      s_d.sys_applied = SYS_FAST_RC;
    end

    // Reference calibration: M counts divided ticks over N reference edges
    if (s_q.cal_start) begin
      if (divn_tick_w) begin
        s_d.cal_m = s_q.cal_m + 32'h1;
      end
      if (ref_edge) begin
        if (s_q.cal_left <= CAL_ONE) begin
          s_d.cal_res = s_q.cal_m + {31'h0, divn_tick_w};
          s_d.cal_start = 1'b0;
        end else begin
          s_d.cal_left = s_q.cal_left - CAL_ONE;
        end
      end
    end

    // Read data is taken in the setup phase so prdata comes from a flop
    rd = '0;
    if (apb_req.paddr == TRIM_OFS) begin
      rd[TRIM_W-1:0] = s_q.trim_code;
    end else if (apb_req.paddr == CLKSEL_OFS) begin
      rd[LP_SEL_LSB +: 2] = s_q.lp_sel;
      rd[SYS_SEL_LSB +: 3] = s_q.sys_sel;
      rd[EXT_DIV_LSB +: DIV_W] = s_q.ext_div;
    end else if (apb_req.paddr == TRIMCTRL_OFS) begin
      rd[TRIM_SEL_LSB +: 2] = s_q.trim_select;
      rd[COUNT_N_LSB +: CNTN_W] = s_q.count_n;
    end else if (apb_req.paddr == RDYSTART_OFS) begin
      rd[RDY_W-1:0] = s_q.rdy_start;
    end else if (apb_req.paddr == RDYCAP_OFS) begin
      rd[RDY_W-1:0] = s_q.rdy_cap;
    end else if (apb_req.paddr == STATUS_OFS) begin
      rd[ST_TRIM_DONE_BIT] = s_q.trim_done;
      rd[ST_XTAL_EN_BIT] = s_q.xtal_en;
      rd[ST_SEQ_LSB +: 2] = s_q.seq;
      rd[ST_PLL_LSB +: 2] = s_q.pll;
      rd[ST_RDY_LSB +: RDY_W] = s_q.rdy_cnt;
    end else if (apb_req.paddr == CALCTRL_OFS) begin
      rd[REF_SEL_LSB +: 2] = s_q.ref_sel;
      rd[CAL_START_BIT] = s_q.cal_start;
    end else if (apb_req.paddr == CALN_OFS) begin
      rd[CALN_W-1:0] = s_q.cal_n;
    end else if (apb_req.paddr == CALRES_OFS) begin
      rd = s_q.cal_res;
    end
    if (setup) begin
      s_d.prdata = rd;
      s_d.pslverr = !reg_hit(apb_req.paddr);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.trim_code <= TRIM_RST;
      s_q.lp_sel <= LP_SEL_RST;
      s_q.ext_div <= EXT_DIV_RST;
      s_q.count_n <= COUNT_N_RST;
      s_q.rdy_start <= RDY_START_RST;
    end else begin
      s_q <= s_d;
    end
  end

  trim_cap_decoder u_trim (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .code(s_q.trim_applied),
    .caps(trim_caps)
  );

  divn_divider u_divn (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sys_src(sys_clk_sel),
    .ext_div(s_q.ext_div),
    .sys_clk_mon(osc.sys_clk_mon),
    .divn_tick(divn_tick_w)
  );

  assign apb_rsp = {1'b1, s_q.prdata, s_q.pslverr};
  assign low_power_sleep_clock = s_q.lp_sel;
  // Core runs on the fast RC while the sequence is in start-up or settling
  assign sys_clk_sel = (s_q.seq == SEQ_STARTUP || s_q.seq == SEQ_SETTLE) ?
                       SYS_FAST_RC : s_q.sys_applied;
  assign fast_crystal_enable = s_q.xtal_en;
  assign pll_enable = s_q.pll != PLL_OFF;
  assign usb48_enable = s_q.pll == PLL_ON;
  assign divn_tick = divn_tick_w;
  assign trim_done_flag = s_q.trim_done;
  assign crystal_ready_interrupt = s_q.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  irq_cause_a: assert property (
    crystal_ready_interrupt |-> $past(s_q.seq) == SEQ_SETTLE && $past(s_q.rdy_cnt) <= RDY_ONE)
    else $error("ready interrupt without counter at one");
  irq_once_a: assert property (
    crystal_ready_interrupt |=> !crystal_ready_interrupt [*8])
    else $error("ready interrupt repeated in one sequence");
  seq_reload_a: assert property (
    (s_q.seq == SEQ_IDLE && (power_up_start || wakeup_start) && !xtal_disable) |=>
      s_q.rdy_cnt == $past(s_q.rdy_start) && fast_crystal_enable)
    else $error("sequence start did not reload counter");
  ok_capture_a: assert property (
    $rose(crystal_amplitude_ok) |-> ##1 s_q.rdy_cap == $past(s_q.rdy_cnt))
    else $error("counter not captured on amplitude ok");
  capture_hold_a: assert property (
    !(crystal_amplitude_ok && !s_q.ok_prev) |=> $stable(s_q.rdy_cap))
    else $error("capture changed without amplitude ok edge");
  trim_apply_a: assert property (
    $rose(trim_done_flag) |-> s_q.trim_applied == $past(s_q.trim_code) &&
      $past(s_q.seq) == SEQ_STARTUP)
    else $error("trim done without trim applied");
  trim_clear_a: assert property (
    (xtal_disable && !s_q.trim_select[1] && s_q.seq != SEQ_STARTUP) |=> !trim_done_flag)
    else $error("trim done kept after crystal disable");
  settle_clock_a: assert property (
    (s_q.seq == SEQ_STARTUP || s_q.seq == SEQ_SETTLE) |-> sys_clk_sel == SYS_FAST_RC)
    else $error("core clock left fast RC during settling");
  sleep_src_a: assert property (
    low_power_sleep_clock != LP_RSVD)
    else $error("sleep clock on reserved source");
  pll_switch_a: assert property (
    (s_q.sys_applied == SYS_PLL && $past(s_q.sys_applied) != SYS_PLL) |-> $past(pll_locked))
    else $error("system clock moved to PLL before lock");
  cal_done_a: assert property (
    $fell(s_q.cal_start) |-> $past(ref_edge) && $past(s_q.cal_left) <= CAL_ONE)
    else $error("calibration ended early");
endmodule : clock_gen_xtal_trim_calib

// file: test/analog_osc_model.sv
// Behavioural oscillators, crystal amplitude detector and PLL lock at the block's far side
`timescale 1ns/100ps
module analog_osc_model
  import clock_gen_pkg::*;
(
  input wire logic core_clk,
  input wire logic xtal_en,
  input wire logic pll_en,
  input wire logic ok_block,
  output osc_in_t osc,
  output logic amp_ok,
  output logic locked
);
  logic [7:0] t_q = 8'h00;
  logic [3:0] ok_q = 4'h0;
  logic [3:0] lk_q = 4'h0;

  always @(posedge core_clk) begin
    t_q <= t_q + 8'h01;
    // Amplitude only builds while the crystal is enabled; ok_block models a detector that never fires
    ok_q <= (xtal_en && !ok_block) ? ok_q + {3'h0, ok_q != 4'hf} : 4'h0;
    lk_q <= pll_en ? lk_q + {3'h0, lk_q != 4'hf} : 4'h0;
  end

  // Crystal stands still while disabled rather than holding its last level
  // One driver for the whole carrier: fast crystal, fast RC, slow RC, slow crystal, enhanced RC,
  // system clock monitor
  assign osc = {xtal_en & t_q[0], t_q[0], t_q[3], t_q[4], t_q[5], t_q[0]};
  assign amp_ok = ok_q > 4'h4;
  assign locked = lk_q > 4'h6;
endmodule : analog_osc_model

// file: test/test_clock_gen_xtal_trim_calib.sv
// Self-checking bench of the clock generation block
`timescale 1ns/100ps
module test_clock_gen_xtal_trim_calib
  import clock_gen_pkg::*;
;
  typedef struct packed {logic [TRIM_W-1:0] code; logic [THERM_W-1:0] therm;} row_t;
  row_t rows [8] = '{'{11'h000, 7'h01}, '{11'h1a5, 7'h01}, '{11'h25a, 7'h03}, '{11'h3ff, 7'h07},
    '{11'h401, 7'h0f}, '{11'h580, 7'h1f}, '{11'h6c3, 7'h3f}, '{11'h7ff, 7'h7f}};
  logic [7:0] ofs [5] = '{TRIM_OFS, CLKSEL_OFS, TRIMCTRL_OFS, RDYSTART_OFS, RDYCAP_OFS};
  logic [31:0] rv [5] = '{32'h0, 32'h101, 32'h4000, 32'h20, 32'h0};
  logic [31:0] per [4] = '{32'h8, 32'h1, 32'h10, 32'h20};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr = 1'b0, wake = 1'b0, xdis = 1'b0, ok_block = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  osc_in_t osc;
  logic amp_ok, locked, pll_en, usb_en, xtal_en, tick, tdone, irq, er;
  logic [1:0] lp_clk;
  sys_src_t sys_sel;
  trim_caps_t caps;
  logic [31:0] rd, p, want;
  int err_total = 0, n_tests = 0;

  clock_gen_xtal_trim_calib i_clock_gen_xtal_trim_calib (.core_clk(core_clk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .osc(osc), .crystal_amplitude_ok(amp_ok), .pll_locked(locked),
    .power_up_start(pwr), .wakeup_start(wake), .xtal_disable(xdis),
    .low_power_sleep_clock(lp_clk), .sys_clk_sel(sys_sel), .fast_crystal_enable(xtal_en),
    .pll_enable(pll_en), .usb48_enable(usb_en), .divn_tick(tick), .trim_caps(caps),
    .trim_done_flag(tdone), .crystal_ready_interrupt(irq));
  analog_osc_model i_analog_osc_model (.core_clk(core_clk), .xtal_en(xtal_en), .pll_en(pll_en),
    .ok_block(ok_block), .osc(osc), .amp_ok(amp_ok), .locked(locked));

  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rng(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, seen >= lo && seen <= hi}, 32'h1);
  endtask : rng

  // Idle edge after release keeps back-to-back calls from driving req twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask : apb

  task automatic ticks(input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] n;
    n = 0;
    repeat (120) begin
      @(posedge core_clk);
      if (tick === 1'b1) n++;
    end
    rng(n, lo, hi);
  endtask : ticks

  // Long enough for the slowest sleep clock to run the ready count out
  task automatic run_seq(input logic wk);
    pwr <= !wk;
    wake <= wk;
    @(posedge core_clk);
    pwr <= 1'b0;
    wake <= 1'b0;
    p = 0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, xtal_en}, 32'h1);
    chk({29'h0, sys_sel}, 32'h0);
    repeat (700) begin
      @(posedge core_clk);
      if (irq === 1'b1) p++;
    end
    chk(p, 32'h1);
  endtask : run_seq

  task automatic stop_xtal();
    xdis <= 1'b1;
    @(posedge core_clk);
    xdis <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : stop_xtal

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #500000;
    err_total++;
    $display("BAD at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, RDYSTART_OFS, 32'h4);
    want = 32'h100;
    foreach (rows[i]) begin
      apb(1'b1, TRIM_OFS, {21'h0, rows[i].code});
      chk({17'h0, caps}, want);
      run_seq(1'b0);
      want = {17'h0, rows[i].therm, rows[i].code[7:0]};
      chk({17'h0, caps}, want);
      chk({31'h0, tdone}, 32'h1);
      apb(1'b0, RDYCAP_OFS, 32'h0);
      rng(rd, 32'h3, 32'h4);
      stop_xtal();
      chk({31'h0, tdone}, 32'h0);
      $display("Trim row %0d done", i);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CLKSEL_OFS, 32'h100 | i);
      chk({30'h0, lp_clk}, (i == 3) ? 32'h2 : i);
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 2) continue;
      apb(1'b1, CLKSEL_OFS, 32'h102 | (i << 4));
      // The applied source follows the written field one edge later
      @(posedge core_clk);
      chk({29'h0, sys_sel}, (i == 7) ? 32'h6 : i);
    end
    apb(1'b1, CLKSEL_OFS, 32'h332);
    ticks(32'd19, 32'd21);
    apb(1'b1, CLKSEL_OFS, 32'h102);
    ticks(32'd59, 32'd61);
    $display("Clock selection done");
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({30'h0, lp_clk}, 32'h1);
    apb(1'b1, RDYCAP_OFS, 32'h55);
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("Reset values done");
    apb(1'b1, RDYSTART_OFS, 32'h4);
    apb(1'b1, CLKSEL_OFS, 32'h160);
    apb(1'b1, TRIMCTRL_OFS, 32'h802);
    apb(1'b1, TRIM_OFS, 32'h7ff);
    ok_block <= 1'b1;
    run_seq(1'b1);
    chk({17'h0, caps}, 32'h7fff);
    apb(1'b1, CLKSEL_OFS, 32'h120);
    for (int k = 0; k < 50 && sys_sel !== SYS_PLL; k++) @(posedge core_clk);
    chk({29'h0, sys_sel}, {29'h0, SYS_PLL});
    chk({30'h0, pll_en, usb_en}, 32'h3);
    ticks(32'd9, 32'd11);
    stop_xtal();
    chk({27'h0, pll_en, tdone, sys_sel}, 32'h8);
    ok_block <= 1'b0;
    $display("Counted start-up and PLL done");
    apb(1'b1, CLKSEL_OFS, 32'h101);
    // Every reference is measured in turn, as software would redo it each interval
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, CALN_OFS, 32'h4);
      apb(1'b1, CALCTRL_OFS, 32'h4 | r);
      apb(1'b1, CALCTRL_OFS, 32'h0);
      rd = 32'h4;
      for (int k = 0; k < 200 && rd[CAL_START_BIT] !== 1'b0; k++) apb(1'b0, CALCTRL_OFS, 32'h0);
      chk({31'h0, rd[CAL_START_BIT]}, 32'h0);
      apb(1'b0, CALRES_OFS, 32'h0);
      rng(rd, per[r] * 3, per[r] * 4 + 1);
    end
    $display("Calibration done");
    give_verdict();
  end
endmodule : test_clock_gen_xtal_trim_calib
